// ### inc/dts_pkg.sv
// constants for the module temperature sensor with presence-info memory
package dts_pkg;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int CONV_TIME_MS = 65;
    localparam int CONV_CYCLES = CONV_TIME_MS * CLK_MHZ * 1000;
    localparam int BUS_STALL_TIMEOUT_TIME_MS = 30;
    localparam int BUS_STALL_TIMEOUT_CYCLES = BUS_STALL_TIMEOUT_TIME_MS * CLK_MHZ * 1000;

    // bus address type codes, arbitrary values
    localparam logic [3:0] SENSOR_TYPE = 4'h3;
    localparam logic [3:0] EEPROM_TYPE = 4'hA;

    // sensor register pointers
    localparam logic [7:0] REG_CFG = 8'h01;
    localparam logic [7:0] REG_UPPER = 8'h02;
    localparam logic [7:0] REG_LOWER = 8'h03;
    localparam logic [7:0] REG_TEMP = 8'h05;
    localparam logic [7:0] REG_LOCK = 8'h06;

    // config field positions and reset value
    localparam int CFG_SHDN_BIT = 0;
    localparam int CFG_LOWPWR_BIT = 1;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_CLR_BIT = 4;
    localparam logic [3:0] CFG_RST = 4'h0;

    // lock register field positions
    localparam int LOCK_SET_REV_BIT = 0;
    localparam int LOCK_CLR_REV_BIT = 1;
    localparam int LOCK_SET_PERM_BIT = 2;

    // temperature in quarter degrees, signed
    localparam int TEMP_W = 11;
    localparam logic signed [10:0] TEMP_MIN = -11'sd160;
    localparam logic signed [10:0] TEMP_MAX = 11'sd500;
    localparam logic signed [10:0] UPPER_RST = 11'sd340;
    localparam logic signed [10:0] LOWER_RST = 11'sd0;
    localparam logic signed [10:0] TEMP_RST = 11'sd100;

    typedef enum logic [1:0] {EVT_CMP_LOW, EVT_CMP_HIGH, EVT_INT} dts_evt_mode_t;
    typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} dts_phase_t;
endpackage : dts_pkg

// ### src/dts_sensor_top.sv
// temperature sensor with event output and 256-byte presence-info memory on a two-wire bus
`timescale 1ns/100ps
// What this block does
// - turns the sensed temperature into a digital word clamped to -40 C .. +125 C.
// - asserts the event output whenever the temperature leaves the programmed limits.
// - event output works as active-low comparator, active-high comparator or interrupt.
// - host settings put the sensor into shutdown or low-power mode.
// - entering shutdown releases the event output whatever its earlier state.
// - the memory is one block of 256 bytes of 8 bits.
// - bytes 0x00 to 0x7F can be locked permanently or reversibly against writes.
// - bytes 0x80 to 0xFF always accept writes.
// - up to eight devices share the bus, each answering only its own address.
// - each conversion at 0.25 C per bit completes in 65 ms, or 130 ms in low-power mode.
module dts_sensor_top
    import dts_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES,
    parameter int BUS_STALL_TIMEOUT_CYC = BUS_STALL_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic [2:0] addr_pin,
    input wire logic signed [10:0] temp_sample,
    output logic sda_out,
    output logic sda_oe_n,
    output logic event_out,
    output logic event_oe_n,
    output logic signed [10:0] temp_value,
    output logic bus_busy,
    output logic write_locked
);

    function automatic logic [15:0] sext16(input logic signed [10:0] v);
        sext16 = {{5{v[10]}}, v};
    endfunction : sext16

    function automatic logic outside(input logic signed [10:0] t,
                                     input logic signed [10:0] hi,
                                     input logic signed [10:0] lo);
        outside = (t > hi) | (t < lo);
    endfunction : outside

    // system clock side: pin synchronisers, bus state, conversion, shadow and event registers
    logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
    logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
    logic [2:0] addr_s1_ff, addr_s2_ff, addr_q_ff;
    logic busy_ff, link_clr_ff, link_por_n_ff;
    logic [31:0] bus_stall_timeout_cnt_ff;
    logic [31:0] conv_cnt_ff;
    logic signed [10:0] temp_ff, temp_pub_ff;
    logic [3:0] cfg_sh_ff;
    logic signed [10:0] upper_sh_ff, lower_sh_ff;
    logic lock_sh_ff;
    logic clr_s1_ff, clr_s2_ff, clr_s3_ff;
    logic evt_latch_ff, event_out_ff, event_oe_n_ff, sda_out_ff;

    // link side
    logic [3:0] bit_cnt_ff;
    logic [7:0] sh_ff, ptr_ff, wr_hi_ff;
    dts_phase_t phase_ff;
    logic sel_ff, rd_ff, tgt_ee_ff, hl_ff;
    logic [3:0] cfg_ff;
    logic signed [10:0] upper_ff, lower_ff;
    logic rev_lock_ff, perm_lock_ff, clr_tgl_ff;
    logic sda_drive_n_ff;
    logic [7:0] mem [0:255];

    // start and stop seen on synchronised pins; the 400 kHz ceiling keeps scl high
    // long enough for the link reset pulse to finish before the first data edge
    wire start_det = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
    wire stop_det = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
    wire bus_stall_timeout_hit = busy_ff & ~scl_s2_ff & (bus_stall_timeout_cnt_ff == 32'(BUS_STALL_TIMEOUT_CYC - 1));
    wire nxt_busy = ~stop_det & ~bus_stall_timeout_hit & (busy_ff | start_det);

    wire shdn = cfg_sh_ff[CFG_SHDN_BIT];
    wire low_pwr = cfg_sh_ff[CFG_LOWPWR_BIT];
    wire [1:0] mode = cfg_sh_ff[CFG_MODE_LSB +: 2];
    wire mode_int = mode == EVT_INT;
    wire mode_high = mode == EVT_CMP_HIGH;
    wire [31:0] conv_period = low_pwr ? 32'(2 * CONV_CYC) : 32'(CONV_CYC);
    // compare with >= so a period shortened by leaving low power still ends
    wire conv_done = ~shdn & (conv_cnt_ff >= conv_period - 32'h1);
    wire signed [10:0] temp_clamped = (temp_sample < TEMP_MIN) ? TEMP_MIN :
        (temp_sample > TEMP_MAX) ? TEMP_MAX : temp_sample;
    wire out_of_win = outside(temp_ff, upper_sh_ff, lower_sh_ff);
    // interrupt latches on the value being converted, not the previous one
    wire conv_out = outside(temp_clamped, upper_sh_ff, lower_sh_ff);
    wire clr_evt = clr_s2_ff ^ clr_s3_ff;
    wire nxt_latch = ~shdn & ((conv_done & conv_out) | (evt_latch_ff & ~clr_evt));
    wire nxt_assert = ~shdn & (mode_int ? evt_latch_ff : out_of_win);

    always_ff @(posedge clk) begin
        scl_s1_ff <= scl;
        scl_s2_ff <= scl_s1_ff;
        scl_s3_ff <= scl_s2_ff;
        sda_s1_ff <= sda_in;
        sda_s2_ff <= sda_s1_ff;
        sda_s3_ff <= sda_s2_ff;
        addr_s1_ff <= addr_pin;
        addr_s2_ff <= addr_s1_ff;
        clr_s1_ff <= clr_tgl_ff;
        clr_s2_ff <= clr_s1_ff;
        clr_s3_ff <= clr_s2_ff;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_ff <= 1'b0;
            link_clr_ff <= 1'b1;
            link_por_n_ff <= 1'b0;
            bus_stall_timeout_cnt_ff <= 32'h0;
            addr_q_ff <= 3'h0;
        end else begin
            busy_ff <= nxt_busy;
            link_clr_ff <= ~nxt_busy | start_det;
            link_por_n_ff <= 1'b1;
            bus_stall_timeout_cnt_ff <= (busy_ff & ~scl_s2_ff) ? bus_stall_timeout_cnt_ff + 32'h1 : 32'h0;
            addr_q_ff <= addr_s2_ff;
        end
    end

    // link registers are copied only while the bus is idle, so they stand still
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg_sh_ff <= CFG_RST;
            upper_sh_ff <= UPPER_RST;
            lower_sh_ff <= LOWER_RST;
            lock_sh_ff <= 1'b0;
            temp_pub_ff <= TEMP_RST;
        end else if (!busy_ff) begin
            cfg_sh_ff <= cfg_ff;
            upper_sh_ff <= upper_ff;
            lower_sh_ff <= lower_ff;
            lock_sh_ff <= rev_lock_ff | perm_lock_ff;
            temp_pub_ff <= temp_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            conv_cnt_ff <= 32'h0;
            temp_ff <= TEMP_RST;
        end else begin
            conv_cnt_ff <= (shdn | conv_done) ? 32'h0 : conv_cnt_ff + 32'h1;
            if (conv_done) begin
                temp_ff <= temp_clamped;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            evt_latch_ff <= 1'b0;
            event_oe_n_ff <= 1'b1;
            event_out_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            evt_latch_ff <= nxt_latch;
            event_oe_n_ff <= ~nxt_assert;
            event_out_ff <= mode_high;
            sda_out_ff <= 1'b0;
        end
    end

    // link side decode
    wire [7:0] rx_byte = {sh_ff[6:0], sda_in};
    wire byte_end = bit_cnt_ff == 4'h7;
    wire ack_slot = bit_cnt_ff == 4'h8;
    wire addr_own = rx_byte[3:1] == addr_q_ff;
    wire hit_ts = (rx_byte[7:4] == SENSOR_TYPE) & addr_own;
    wire hit_ee = (rx_byte[7:4] == EEPROM_TYPE) & addr_own;
    wire locked = rev_lock_ff | perm_lock_ff;
    wire wr_data = byte_end & sel_ff & ~rd_ff & (phase_ff == PH_DATA);
    wire ee_we = wr_data & tgt_ee_ff & (ptr_ff[7] | ~locked);
    wire reg_we = wr_data & ~tgt_ee_ff & hl_ff;
    wire [15:0] reg_wdata = {wr_hi_ff, rx_byte};
    wire [15:0] reg_rd = (ptr_ff == REG_CFG) ? {12'h000, cfg_ff} :
        (ptr_ff == REG_UPPER) ? sext16(upper_ff) :
        (ptr_ff == REG_LOWER) ? sext16(lower_ff) :
        (ptr_ff == REG_TEMP) ? sext16(temp_pub_ff) :
        (ptr_ff == REG_LOCK) ? {14'h0000, perm_lock_ff, rev_lock_ff} : 16'h0000;
    wire [7:0] tx_byte = tgt_ee_ff ? mem[ptr_ff] : (hl_ff ? reg_rd[7:0] : reg_rd[15:8]);
    wire tx_bit = tx_byte[3'(4'h7 - bit_cnt_ff)];
    wire ack_drv = ack_slot & sel_ff & (~rd_ff | (phase_ff == PH_PTR));
    wire rd_drv = ~ack_slot & sel_ff & rd_ff & (phase_ff == PH_DATA) & ~tx_bit;

    always_ff @(posedge scl or posedge link_clr_ff) begin
        if (link_clr_ff) begin
            bit_cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            phase_ff <= PH_ADDR;
            sel_ff <= 1'b0;
            rd_ff <= 1'b0;
            tgt_ee_ff <= 1'b0;
            ptr_ff <= 8'h00;
            hl_ff <= 1'b0;
            wr_hi_ff <= 8'h00;
        end else if (ack_slot) begin
            bit_cnt_ff <= 4'h0;
            if (sel_ff & rd_ff & (phase_ff == PH_PTR)) begin
                phase_ff <= PH_DATA;
            end else if (sel_ff & rd_ff & (phase_ff == PH_DATA)) begin
                if (sda_in) begin
                    sel_ff <= 1'b0;
                end else if (tgt_ee_ff) begin
                    ptr_ff <= ptr_ff + 8'h01;
                end else begin
                    hl_ff <= ~hl_ff;
                end
            end
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            sh_ff <= rx_byte;
            if (byte_end) begin
                unique case (phase_ff)
                    PH_ADDR: begin
                        sel_ff <= hit_ts | hit_ee;
                        tgt_ee_ff <= hit_ee;
                        rd_ff <= rx_byte[0];
                        phase_ff <= PH_PTR;
                    end
                    PH_PTR: begin
                        if (!rd_ff) begin
                            ptr_ff <= rx_byte;
                            hl_ff <= 1'b0;
                            phase_ff <= PH_DATA;
                        end
                    end
                    PH_DATA: begin
                        if (sel_ff & ~rd_ff & tgt_ee_ff) begin
                            ptr_ff <= ptr_ff + 8'h01;
                        end else if (sel_ff & ~rd_ff) begin
                            wr_hi_ff <= rx_byte;
                            hl_ff <= ~hl_ff;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge scl) begin
        if (ee_we) begin
            mem[ptr_ff] <= rx_byte;
        end
    end

    always_ff @(posedge scl or negedge link_por_n_ff) begin
        if (!link_por_n_ff) begin
            cfg_ff <= CFG_RST;
            upper_ff <= UPPER_RST;
            lower_ff <= LOWER_RST;
            rev_lock_ff <= 1'b0;
            perm_lock_ff <= 1'b0;
            clr_tgl_ff <= 1'b0;
        end else if (reg_we) begin
            if (ptr_ff == REG_CFG) begin
                cfg_ff <= reg_wdata[3:0];
                if (reg_wdata[CFG_CLR_BIT]) begin
                    clr_tgl_ff <= ~clr_tgl_ff;
                end
            end
            if (ptr_ff == REG_UPPER) begin
                upper_ff <= reg_wdata[10:0];
            end
            if (ptr_ff == REG_LOWER) begin
                lower_ff <= reg_wdata[10:0];
            end
            if (ptr_ff == REG_LOCK) begin
                if (reg_wdata[LOCK_SET_REV_BIT]) begin
                    rev_lock_ff <= 1'b1;
                end else if (reg_wdata[LOCK_CLR_REV_BIT] & ~perm_lock_ff) begin
                    rev_lock_ff <= 1'b0;
                end
                if (reg_wdata[LOCK_SET_PERM_BIT]) begin
                    perm_lock_ff <= 1'b1;
                end
            end
        end
    end

    // open-drain data drive changes on the falling scl edge
    always_ff @(negedge scl or posedge link_clr_ff) begin
        if (link_clr_ff) begin
            sda_drive_n_ff <= 1'b1;
        end else begin
            sda_drive_n_ff <= ~(ack_drv | rd_drv);
        end
    end

    assign sda_out = sda_out_ff;
    assign sda_oe_n = sda_drive_n_ff;
    assign event_out = event_out_ff;
    assign event_oe_n = event_oe_n_ff;
    assign temp_value = temp_ff;
    assign bus_busy = busy_ff;
    assign write_locked = lock_sh_ff;

endmodule : dts_sensor_top

// ### bench/dts_sensor_top_chk.sv
// port checks for the temperature sensor top
`timescale 1ns/100ps
module dts_sensor_top_chk
    import dts_pkg::*;
#(
    parameter int CONV_CYC = 50,
    parameter int BUS_STALL_TIMEOUT_CYC = 40
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_oe_n,
    input wire logic event_out,
    input wire logic signed [10:0] temp_value,
    input wire logic bus_busy,
    input wire logic write_locked
);
    int low_cnt;
    int conv_cnt;
    always_ff @(posedge clk) begin
        low_cnt <= (!resetn || scl) ? 0 : low_cnt + 1;
        conv_cnt <= (!resetn || $changed(temp_value)) ? 1 : conv_cnt + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_start;
        scl && $fell(sda_in);
    endsequence
    property p_busy_start; s_start |-> ##[1:4] bus_busy; endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy missing");
    property p_oe_scl; $changed(sda_oe_n) |-> !scl || !bus_busy; endproperty
    a_oe_scl: assert property (p_oe_scl) else $error("sda moved in high");
    property p_idle; !bus_busy [*4] |-> sda_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("sda held when idle");
    property p_bus_stall_timeout; low_cnt > BUS_STALL_TIMEOUT_CYC + 6 |-> !bus_busy; endproperty
    a_bus_stall_timeout: assert property (p_bus_stall_timeout) else $error("no timeout");
    property p_early; bus_busy && low_cnt > 0 && low_cnt < BUS_STALL_TIMEOUT_CYC - 4 |=> bus_busy;
    endproperty
    a_early: assert property (p_early) else $error("early timeout");
    property p_range; temp_value >= TEMP_MIN && temp_value <= TEMP_MAX; endproperty
    a_range: assert property (p_range) else $error("temp out of range");
    property p_conv; $changed(temp_value) |-> conv_cnt >= CONV_CYC - 2; endproperty
    a_conv: assert property (p_conv) else $error("conversion too fast");
    property p_lock; $changed(write_locked) |-> !$past(bus_busy); endproperty
    a_lock: assert property (p_lock) else $error("lock moved in frame");
    property p_evt; $changed(event_out) |-> !$past(bus_busy); endproperty
    a_evt: assert property (p_evt) else $error("polarity moved in frame");
endmodule : dts_sensor_top_chk
bind dts_sensor_top dts_sensor_top_chk #(.CONV_CYC(CONV_CYC), .BUS_STALL_TIMEOUT_CYC(BUS_STALL_TIMEOUT_CYC)) i_chk (
    .clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
    .event_out(event_out), .temp_value(temp_value), .bus_busy(bus_busy),
    .write_locked(write_locked));

// ### bench/dts_host_model.sv
// two-wire host controller model, clock stands high between frames
`timescale 1ns/100ps
module dts_host_model (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    initial begin
        scl = 1;
        sda_drv = 1;
    end
    // quarter periods of 12 ns give the bench link period of 48 ns
    task automatic bit_f(input logic b, output logic r);
        #12 sda_drv = b;
        #12 scl = 1;
        #12 r = sda;
        #12 scl = 0;
    endtask : bit_f
    task automatic start_f();
        sda_drv = 1;
        #12 scl = 1;
        #12 sda_drv = 0;
        #12 scl = 0;
    endtask : start_f
    task automatic stop_f();
        #12 sda_drv = 0;
        #12 scl = 1;
        #12 sda_drv = 1;
        #12;
    endtask : stop_f
    task automatic byte_f(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                          output logic a_out);
        for (int i = 7; i >= 0; i--) bit_f(d[i], q[i]);
        bit_f(a_in, a_out);
    endtask : byte_f
endmodule : dts_host_model

// ### bench/dts_sensor_top_tb.sv
// self-checking bench for the temperature sensor top
`timescale 1ns/100ps
module dts_sensor_top_tb;
    import dts_pkg::*;
    logic clk = 0;
    logic resetn = 0;
    logic [2:0] addr_pin = 3'h0;
    logic signed [10:0] temp_sample = 11'h064;
    logic [7:0] q;
    logic ack;
    logic lk = 0;
    wire scl, h_sda, sda_out, sda_oe_n, event_out, event_oe_n, bus_busy, write_locked;
    wire signed [10:0] temp_value;
    wire sda = h_sda & (sda_oe_n | sda_out);
    int num_errors = 0;
    int n_compared = 0;
    int seed = 91;
    int cyc = 0;
    int mem [256];
    always #2.5 clk = ~clk;
    dts_host_model i_host (.scl(scl), .sda_drv(h_sda), .sda(sda));
    dts_sensor_top #(.CONV_CYC(50), .BUS_STALL_TIMEOUT_CYC(40)) i_dut (
        .clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda), .addr_pin(addr_pin),
        .temp_sample(temp_sample), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .event_out(event_out), .event_oe_n(event_oe_n), .temp_value(temp_value),
        .bus_busy(bus_busy), .write_locked(write_locked));
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk
    function automatic logic [10:0] clamp(input int t);
        return t > TEMP_MAX ? TEMP_MAX : (t < TEMP_MIN ? TEMP_MIN : 11'(t));
    endfunction : clamp
    task automatic send(input logic [7:0] b);
        i_host.byte_f(b, 1'b1, q, ack);
        chk({10'h000, ack}, 11'h000, "no ack");
    endtask : send
    task automatic reg_wr(input logic [7:0] p, input logic [15:0] v);
        i_host.start_f();
        send({SENSOR_TYPE, addr_pin, 1'b0});
        send(p);
        send(v[15:8]);
        send(v[7:0]);
        i_host.stop_f();
        repeat (10) @(negedge clk);
    endtask : reg_wr
    task automatic set_t(input int t);
        @(negedge clk) temp_sample = 11'(t);
        repeat (230) @(negedge clk);
        chk(temp_value, clamp(t), "temp");
    endtask : set_t
    task automatic mem_wr(input logic [7:0] a, input int n);
        logic [7:0] d;
        i_host.start_f();
        send({EEPROM_TYPE, addr_pin, 1'b0});
        send(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            send(d);
            if (!lk || a + i >= 8'h80) mem[(a + i) % 256] = d;
        end
        i_host.stop_f();
        repeat (10) @(negedge clk);
        chk({10'h000, write_locked}, {10'h000, lk}, "lock flag");
    endtask : mem_wr
    task automatic mem_rd(input int n);
        i_host.start_f();
        send({EEPROM_TYPE, addr_pin, 1'b1});
        for (int i = 0; i < n; i++) begin
            i_host.byte_f(8'hFF, i == n - 1, q, ack);
            if (mem[i] >= 0) chk({3'h0, q}, mem[i][10:0], "mem data");
        end
        i_host.stop_f();
        repeat (10) @(negedge clk);
    endtask : mem_rd
    initial begin
        foreach (mem[i]) mem[i] = -1;
        addr_pin = 3'($random(seed));
        repeat (4) @(negedge clk);
        resetn = 1;
        repeat (6) @(negedge clk);
        for (int a = 0; a < 8; a++) begin
            i_host.start_f();
            i_host.byte_f({SENSOR_TYPE, a[2:0], 1'b0}, 1'b1, q, ack);
            i_host.stop_f();
            chk({10'h000, ack}, {10'h000, a[2:0] != addr_pin}, "address");
        end
        $display("address test done");
        set_t(700);
        set_t(-300);
        set_t($random(seed) % 400);
        reg_wr(REG_CFG, 16'h0002);
        set_t(123);
        $display("temperature test done");
        for (int m = 0; m < 3; m++) begin
            reg_wr(REG_CFG, 16'(m << 2));
            set_t(400);
            chk({9'h000, event_oe_n, event_out}, {9'h000, 1'b0, m == 1}, "evt out");
            set_t(200);
            chk({9'h000, event_oe_n, event_out}, {9'h000, m != 2, m == 1}, "evt in");
            reg_wr(REG_CFG, 16'((m << 2) | 16));
            chk({10'h000, event_oe_n}, 11'h001, "evt clear");
            set_t(400);
            reg_wr(REG_CFG, 16'((m << 2) | 1));
            chk({9'h000, event_oe_n, event_out}, {9'h000, 1'b1, m == 1}, "evt shdn");
        end
        reg_wr(REG_UPPER, 16'h01C2);
        reg_wr(REG_CFG, 16'h0000);
        set_t(400);
        chk({10'h000, event_oe_n}, 11'h001, "upper limit");
        set_t(-10);
        chk({10'h000, event_oe_n}, 11'h000, "lower limit");
        $display("event test done");
        mem_wr(8'h00, 130);
        mem_wr(8'h7E, 4);
        reg_wr(REG_LOCK, 16'h0001);
        lk = 1;
        mem_wr(8'h00, 2);
        mem_wr(8'h7E, 4);
        mem_rd(130);
        reg_wr(REG_LOCK, 16'h0002);
        lk = 0;
        mem_wr(8'h01, 1);
        reg_wr(REG_LOCK, 16'h0004);
        lk = 1;
        reg_wr(REG_LOCK, 16'h0002);
        mem_wr(8'h00, 2);
        mem_rd(3);
        $display("memory test done");
        i_host.start_f();
        send({EEPROM_TYPE, addr_pin, 1'b0});
        repeat (60) @(negedge clk);
        chk({10'h000, bus_busy}, 11'h000, "timeout");
        i_host.stop_f();
        mem_rd(1);
        $display("timeout test done");
        close_out();
    end
endmodule : dts_sensor_top_tb
